// File: src/dee_ctrl.sv
module dee_ctrl #(
  parameter int unsigned WRITE_CYCLES = dee_pkg::DEE_CYCLE_CLOCKS,
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // System resets that abort a running cycle
  input wire logic master_clear_reset,
  input wire logic watchdog_timeout,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Status
  output logic nvm_done_flag,
  output logic nvm_busy
);
  import dee_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic go;
    logic enable;
    logic abort_err;
    logic [DEE_CTL_OP_W-1:0] op;
    logic [15:0] addr_low;
    logic [7:0] addr_upper;
    dee_key_type key;
    logic [31:0] cnt;
    logic [15:0] tbl_ptr;
    logic [7:0] tbl_page;
    logic done;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [DEE_BLOCK_WORDS-1:0][15:0] latch;
  } dee_state_type;

  localparam logic [31:0] LAST_CNT = 32'(WRITE_CYCLES - 1);
  localparam int IDX_W = $clog2(DEE_WORDS);
  localparam int BLK_W = $clog2(DEE_BLOCK_WORDS);

  dee_state_type state_q;
  dee_state_type state_d;
  logic [15:0] mem_q [DEE_WORDS];

  logic acc_done;
  logic wr_done;
  logic rd_phase;
  logic sys_reset;
  logic commit;
  logic tbl_in_window;
  logic [IDX_W-1:0] tbl_idx;
  logic [IDX_W-1:0] op_idx;
  logic [IDX_W-BLK_W-1:0] op_blk;
  logic [ADDR_W-1:0] addr_w;
  logic op_valid;

  // ==========================================================================
  // Address decoding and derived terms
  assign addr_w = paddr;
  assign acc_done = psel && penable && state_q.pready;
  assign wr_done = acc_done && pwrite;
  assign rd_phase = psel && penable && !state_q.pready;
  assign sys_reset = master_clear_reset || watchdog_timeout;
  // Window covers page 0x7F, offsets 0xF000 and up
  assign tbl_in_window = (state_q.tbl_page == DEE_WIN_PAGE) &&
                         (state_q.tbl_ptr[15:12] == DEE_WIN_TOP);
  assign tbl_idx = state_q.tbl_ptr[IDX_W:1];
  // Word index from the low address register alone
  assign op_idx = state_q.addr_low[IDX_W:1];
  assign op_blk = op_idx[IDX_W-1:BLK_W];
  // Last cycle of a running operation commits it
  assign commit = state_q.go && (state_q.cnt == LAST_CNT) && !sys_reset;

  // Operation code check for a start request
  always_comb begin
    case (pwdata[DEE_CTL_OP_W-1:0])
      DEE_OP_BLOCK_ERASE: op_valid = 1'b1;
      DEE_OP_WORD_ERASE: op_valid = 1'b1;
      DEE_OP_WORD_PROG: op_valid = 1'b1;
      DEE_OP_BLOCK_PROG: op_valid = 1'b1;
      default: op_valid = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next-state logic
  always_comb begin
    state_d = state_q;
    // APB answer: one wait cycle, then pready for one cycle
    state_d.pready = rd_phase;
    state_d.pslverr = 1'b0;
    if (rd_phase) begin
      state_d.prdata = 32'h00000000;
      unique case (addr_w)
        DEE_ADDR_CONTROL: begin
          state_d.prdata[DEE_CTL_GO_BIT] = state_q.go;
          state_d.prdata[DEE_CTL_EN_BIT] = state_q.enable;
          state_d.prdata[DEE_CTL_ERR_BIT] = state_q.abort_err;
          state_d.prdata[DEE_CTL_OP_W-1:0] = state_q.op;
        end
        DEE_ADDR_ADDR_LOW: state_d.prdata[15:0] = state_q.addr_low;
        DEE_ADDR_ADDR_UPPER: state_d.prdata[7:0] = state_q.addr_upper;
        DEE_ADDR_UNLOCK_KEY: state_d.prdata = 32'h00000000;
        DEE_ADDR_TBL_PTR: state_d.prdata[15:0] = state_q.tbl_ptr;
        DEE_ADDR_TBL_PAGE: state_d.prdata[7:0] = state_q.tbl_page;
        DEE_ADDR_TBL_DATA: begin
          // Table read; stale contents while a cycle runs
          if (tbl_in_window) begin
            state_d.prdata[15:0] = mem_q[tbl_idx];
          end else begin
            state_d.pslverr = 1'b1;
          end
        end
        DEE_ADDR_IRQ_FLAG: state_d.prdata[DEE_DONE_BIT] = state_q.done;
        default: state_d.pslverr = 1'b1;
      endcase
      // Table write outside the window is refused
      if (pwrite && (addr_w == DEE_ADDR_TBL_DATA) && !tbl_in_window) begin
        state_d.pslverr = 1'b1;
      end
    end

    // Running cycle: count, then clear go and raise done
    if (state_q.go) begin
      state_d.cnt = state_q.cnt + 32'h00000001;
      if (commit) begin
        state_d.go = 1'b0;
        state_d.cnt = 32'h00000000;
      end
    end

    // Any completed access disarms the key unless it advances it
    if (acc_done) begin
      state_d.key = DEE_KEY_IDLE;
    end

    if (wr_done) begin
      unique case (addr_w)
        DEE_ADDR_CONTROL: begin
          state_d.enable = pwdata[DEE_CTL_EN_BIT];
          state_d.abort_err = pwdata[DEE_CTL_ERR_BIT];
          if (!state_q.go) begin
            state_d.op = pwdata[DEE_CTL_OP_W-1:0];
          end
          // Start needs earlier enable, fresh key and a known operation
          if (pwdata[DEE_CTL_GO_BIT] && state_q.enable && !state_q.go &&
              (state_q.key == DEE_KEY_ARMED) && op_valid) begin
            state_d.go = 1'b1;
            state_d.cnt = 32'h00000000;
          end
        end
        DEE_ADDR_ADDR_LOW: state_d.addr_low = pwdata[15:0];
        DEE_ADDR_ADDR_UPPER: state_d.addr_upper = pwdata[7:0];
        DEE_ADDR_UNLOCK_KEY: begin
          if (pwdata[7:0] == DEE_KEY_FIRST) begin
            state_d.key = DEE_KEY_GOT_FIRST;
          end else if ((pwdata[7:0] == DEE_KEY_SECOND) &&
                       (state_q.key == DEE_KEY_GOT_FIRST)) begin
            state_d.key = DEE_KEY_ARMED;
          end else begin
            state_d.key = DEE_KEY_IDLE;
          end
        end
        DEE_ADDR_TBL_PTR: state_d.tbl_ptr = pwdata[15:0];
        DEE_ADDR_TBL_PAGE: state_d.tbl_page = pwdata[7:0];
        DEE_ADDR_TBL_DATA: begin
          if (tbl_in_window) begin
            // Fill one latch and capture its address
            state_d.latch[tbl_idx[BLK_W-1:0]] = pwdata[15:0];
            state_d.addr_low = state_q.tbl_ptr;
            state_d.addr_upper = state_q.tbl_page;
          end
        end
        DEE_ADDR_IRQ_FLAG: begin
          if (!pwdata[DEE_DONE_BIT]) begin
            state_d.done = 1'b0;
          end
        end
        default: state_d.done = state_q.done;
      endcase
    end

    // Completion wins over a software clear in the same cycle
    if (commit) begin
      state_d.done = 1'b1;
    end

    // Master-clear or watchdog: abort, flag error, keep address
    if (sys_reset) begin
      if (state_q.go) begin
        state_d.abort_err = 1'b1;
      end
      state_d.go = 1'b0;
      state_d.cnt = 32'h00000000;
      state_d.enable = 1'b0;
      state_d.op = '0;
      state_d.key = DEE_KEY_IDLE;
    end
  end

  // ==========================================================================
  // State register; power-up clears enable and everything else
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
      state_q.key <= DEE_KEY_IDLE;
      state_q.addr_low <= DEE_LOW_RESET;
      state_q.addr_upper <= DEE_UPPER_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // EEPROM array; effects land at the end of the cycle
  always_ff @(posedge pclk) begin
    if (commit) begin
      for (int i = 0; i < DEE_BLOCK_WORDS; i++) begin
        case (state_q.op)
          DEE_OP_BLOCK_ERASE: begin
            mem_q[{op_blk, BLK_W'(i)}] <= DEE_ERASED;
          end
          DEE_OP_WORD_ERASE: begin
            if (op_idx[BLK_W-1:0] == BLK_W'(i)) begin
              mem_q[op_idx] <= DEE_ERASED;
            end
          end
          DEE_OP_WORD_PROG: begin
            if (op_idx[BLK_W-1:0] == BLK_W'(i)) begin
              mem_q[op_idx] <= state_q.latch[i];
            end
          end
          DEE_OP_BLOCK_PROG: begin
            mem_q[{op_blk, BLK_W'(i)}] <= state_q.latch[i];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Outputs straight from the state register
  assign prdata = state_q.prdata;
  assign pready = state_q.pready;
  assign pslverr = state_q.pslverr;
  assign nvm_done_flag = state_q.done;
  assign nvm_busy = state_q.go;

endmodule : dee_ctrl

// File: inc/dee_pkg.sv
package dee_pkg;

  // ==========================================================================
  // Register indices; the byte address on APB is four times the index
  localparam logic [15:0] DEE_IDX_CONTROL = 16'h0760;
  localparam logic [15:0] DEE_IDX_ADDR_LOW = 16'h0762;
  localparam logic [15:0] DEE_IDX_ADDR_UPPER = 16'h0764;
  localparam logic [15:0] DEE_IDX_UNLOCK_KEY = 16'h0766;
  localparam logic [15:0] DEE_IDX_TBL_PTR = 16'h0768;
  localparam logic [15:0] DEE_IDX_TBL_PAGE = 16'h076A;
  localparam logic [15:0] DEE_IDX_TBL_DATA = 16'h076C;
  localparam logic [15:0] DEE_IDX_IRQ_FLAG = 16'h076E;
  localparam logic [15:0] DEE_ADDR_CONTROL = 16'(DEE_IDX_CONTROL * 4);
  localparam logic [15:0] DEE_ADDR_ADDR_LOW = 16'(DEE_IDX_ADDR_LOW * 4);
  localparam logic [15:0] DEE_ADDR_ADDR_UPPER = 16'(DEE_IDX_ADDR_UPPER * 4);
  localparam logic [15:0] DEE_ADDR_UNLOCK_KEY = 16'(DEE_IDX_UNLOCK_KEY * 4);
  localparam logic [15:0] DEE_ADDR_TBL_PTR = 16'(DEE_IDX_TBL_PTR * 4);
  localparam logic [15:0] DEE_ADDR_TBL_PAGE = 16'(DEE_IDX_TBL_PAGE * 4);
  localparam logic [15:0] DEE_ADDR_TBL_DATA = 16'(DEE_IDX_TBL_DATA * 4);
  localparam logic [15:0] DEE_ADDR_IRQ_FLAG = 16'(DEE_IDX_IRQ_FLAG * 4);

  // ==========================================================================
  // Control and flag register fields
  localparam int DEE_CTL_GO_BIT = 15;
  localparam int DEE_CTL_EN_BIT = 14;
  localparam int DEE_CTL_ERR_BIT = 13;
  localparam int DEE_CTL_OP_W = 7;
  localparam int DEE_DONE_BIT = 0;

  // Operation codes in the low control bits
  localparam logic [6:0] DEE_OP_BLOCK_ERASE = 7'h45;
  localparam logic [6:0] DEE_OP_WORD_ERASE = 7'h44;
  localparam logic [6:0] DEE_OP_WORD_PROG = 7'h04;
  localparam logic [6:0] DEE_OP_BLOCK_PROG = 7'h0A;

  // Unlock key values
  localparam logic [7:0] DEE_KEY_FIRST = 8'h55;
  localparam logic [7:0] DEE_KEY_SECOND = 8'hAA;

  // ==========================================================================
  // Memory window in program space
  localparam logic [7:0] DEE_WIN_PAGE = 8'h7F;
  localparam logic [3:0] DEE_WIN_TOP = 4'hF;
  localparam int DEE_WORDS = 4096;
  localparam int DEE_BLOCK_WORDS = 16;
  localparam logic [15:0] DEE_ERASED = 16'hFFFF;
  localparam logic [7:0] DEE_UPPER_RESET = 8'h00;
  localparam logic [15:0] DEE_LOW_RESET = 16'h0000;

  // ==========================================================================
  // Timing: write or erase cycle
  localparam int DEE_CLK_MHZ = 40;
  localparam int DEE_CYCLE_TIME_US = 2000;
  localparam int DEE_CYCLE_CLOCKS = DEE_CYCLE_TIME_US * DEE_CLK_MHZ;

  // Unlock sequencer states
  typedef enum logic [1:0] {
    DEE_KEY_IDLE = 2'b00,
    DEE_KEY_GOT_FIRST = 2'b01,
    DEE_KEY_ARMED = 2'b10
  } dee_key_type;

endpackage : dee_pkg

// File: tb/dee_ctrl_asserts.sv
module dee_chk #(
  parameter int unsigned WRITE_CYCLES = 20,
  parameter int ADDR_W = 16
) (
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic master_clear_reset,
  input wire logic watchdog_timeout,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status
  input wire logic nvm_done_flag,
  input wire logic nvm_busy
);
  import dee_pkg::*;
  logic [31:0] cnt_q;
  logic acc;
  logic sys_rst;
  logic go_wr;
  // Completed transfers, abort requests and go writes
  assign acc = psel && penable && pready;
  assign sys_rst = master_clear_reset || watchdog_timeout;
  assign go_wr = acc && pwrite && paddr == DEE_ADDR_CONTROL && pwdata[DEE_CTL_GO_BIT];
  // Counts edges that saw a running cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= nvm_busy ? cnt_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_enter; psel && !penable ##1 psel && penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  AST_ONE_WAIT: assert property (s_enter |-> s_answer)
    else $error("pready not after one wait state");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_WITH_RDY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAPPED: assert property (acc && (paddr < DEE_ADDR_CONTROL
    || paddr > DEE_ADDR_IRQ_FLAG) |-> pslverr)
    else $error("unmapped access not refused");
  AST_GO_CAUSE: assert property ($rose(nvm_busy) |-> $past(go_wr))
    else $error("cycle started without go write");
  AST_GO_HOLD: assert property (nvm_busy && !sys_rst && cnt_q < WRITE_CYCLES - 1
    |=> nvm_busy)
    else $error("go cleared early");
  AST_LENGTH: assert property ($fell(nvm_busy) && !$past(sys_rst)
    |-> cnt_q == WRITE_CYCLES)
    else $error("cycle length wrong");
  AST_DONE_CAUSE: assert property ($rose(nvm_done_flag) |-> $fell(nvm_busy))
    else $error("done without completion");
  AST_DONE_KEEP: assert property (nvm_done_flag && !(acc && pwrite
    && paddr == DEE_ADDR_IRQ_FLAG && !pwdata[0]) |=> nvm_done_flag)
    else $error("done cleared by hardware");
  AST_ABORT: assert property (sys_rst |=> !nvm_busy)
    else $error("cycle not aborted");
endmodule : dee_chk

bind dee_ctrl dee_chk #(.WRITE_CYCLES(WRITE_CYCLES), .ADDR_W(ADDR_W)) i_dee_chk (
  .pclk(pclk), .presetn(presetn), .master_clear_reset(master_clear_reset),
  .watchdog_timeout(watchdog_timeout), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .nvm_done_flag(nvm_done_flag), .nvm_busy(nvm_busy));

// File: tb/dee_host.sv
module dee_host (
  // Clock and answer
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import dee_pkg::*;
  logic tmo = 1'b0;
  logic [31:0] rd_q = 32'h0;
  logic err_q = 1'b0;
  // Idle bus at start
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
  end
  // One transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_q = prdata;
    err_q = pslverr;
    if (n >= 20) tmo = 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
  // Key pair directly before the go write
  task automatic unlock_go(input logic [15:0] ctl);
    xfer(1'b1, DEE_ADDR_UNLOCK_KEY, {24'h0, DEE_KEY_FIRST});
    xfer(1'b1, DEE_ADDR_UNLOCK_KEY, {24'h0, DEE_KEY_SECOND});
    xfer(1'b1, DEE_ADDR_CONTROL, {16'h0, ctl});
  endtask : unlock_go
endmodule : dee_host

// File: tb/tb.sv
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dee_pkg::*;
  localparam int unsigned WC = 20;
  typedef struct {logic [15:0] a; logic [31:0] w; logic [31:0] r; logic e;} dee_row_type;
  logic pclk = 1'b0, presetn = 1'b0, master_clear_reset = 1'b0, watchdog_timeout = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, nvm_done_flag, nvm_busy;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  int error_cnt = 0;
  int comparisons = 0;
  dee_row_type rows [7] = '{
    '{DEE_ADDR_ADDR_LOW, 32'h0000F246, 32'h0000F246, 1'b0},
    '{DEE_ADDR_ADDR_UPPER, 32'h0000017F, 32'h0000007F, 1'b0},
    '{DEE_ADDR_UNLOCK_KEY, 32'h00000055, 32'h0, 1'b0},
    '{DEE_ADDR_IRQ_FLAG, 32'h1, 32'h0, 1'b0},
    '{DEE_ADDR_TBL_PAGE, 32'h7F, 32'h7F, 1'b0},
    '{DEE_ADDR_TBL_DATA, 32'h1, 32'h0, 1'b1},
    '{16'h1D84, 32'h1, 32'h0, 1'b1}};
  always #12.5 pclk = ~pclk;
  dee_ctrl #(.WRITE_CYCLES(WC)) i_dee_ctrl (.pclk(pclk), .presetn(presetn),
    .master_clear_reset(master_clear_reset), .watchdog_timeout(watchdog_timeout),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_done_flag(nvm_done_flag),
    .nvm_busy(nvm_busy));
  dee_host i_dee_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // ==========================================================================
  // Helpers
  task automatic close_out;
    if (i_dee_host.tmo !== 1'b0) error_cnt++;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    i_dee_host.xfer(w, a, d);
    if (i_dee_host.tmo) close_out();
  endtask : bus
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    `CHK(i_dee_host.rd_q, exp)
  endtask : rd_chk
  task automatic go(input logic [15:0] ctl);
    i_dee_host.unlock_go(ctl);
    if (i_dee_host.tmo) close_out();
    @(negedge pclk);
  endtask : go
  task automatic peek(input logic [15:0] ptr, input logic [31:0] exp);
    bus(1'b1, DEE_ADDR_TBL_PTR, {16'h0, ptr});
    rd_chk(DEE_ADDR_TBL_DATA, exp);
  endtask : peek
  task automatic wait_idle;
    int n;
    n = 0;
    while (nvm_busy !== 1'b0 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 100) begin
      error_cnt++;
      close_out();
    end
  endtask : wait_idle
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(DEE_ADDR_CONTROL, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      `CHK(i_dee_host.err_q, rows[i].e)
      rd_chk(rows[i].a, rows[i].r);
    end
    bus(1'b1, DEE_ADDR_CONTROL, 32'h4045);
    bus(1'b1, DEE_ADDR_UNLOCK_KEY, 32'h55);
    rd_chk(DEE_ADDR_ADDR_UPPER, 32'h7F);
    bus(1'b1, DEE_ADDR_UNLOCK_KEY, 32'hAA);
    bus(1'b1, DEE_ADDR_CONTROL, 32'h0000C045);
    @(negedge pclk);
    `CHK(nvm_busy, 1'b0)
    bus(1'b1, DEE_ADDR_CONTROL, 32'h0000C045);
    @(negedge pclk);
    `CHK(nvm_busy, 1'b0)
    bus(1'b1, DEE_ADDR_CONTROL, 32'h0045);
    go(16'hC045);
    `CHK(nvm_busy, 1'b0)
    bus(1'b1, DEE_ADDR_TBL_PTR, 32'hF004);
    bus(1'b1, DEE_ADDR_TBL_DATA, 32'h1111);
    bus(1'b1, DEE_ADDR_CONTROL, 32'h4044);
    go(16'hC044);
    `CHK(nvm_busy, 1'b1)
    bus(1'b1, DEE_ADDR_CONTROL, 32'h0044);
    rd_chk(DEE_ADDR_CONTROL, 32'h8044);
    wait_idle();
    `CHK(nvm_done_flag, 1'b1)
    rd_chk(DEE_ADDR_TBL_DATA, 32'hFFFF);
    bus(1'b1, DEE_ADDR_TBL_DATA, 32'hBEEF);
    rd_chk(DEE_ADDR_ADDR_LOW, 32'hF004);
    bus(1'b1, DEE_ADDR_CONTROL, 32'h4004);
    go(16'hC004);
    wait_idle();
    rd_chk(DEE_ADDR_CONTROL, 32'h4004);
    rd_chk(DEE_ADDR_TBL_DATA, 32'hBEEF);
    bus(1'b1, DEE_ADDR_IRQ_FLAG, 32'h1);
    rd_chk(DEE_ADDR_IRQ_FLAG, 32'h1);
    bus(1'b1, DEE_ADDR_IRQ_FLAG, 32'h0);
    @(negedge pclk);
    `CHK(nvm_done_flag, 1'b0)
    bus(1'b1, DEE_ADDR_TBL_PTR, 32'hF020);
    bus(1'b1, DEE_ADDR_TBL_DATA, 32'h0);
    bus(1'b1, DEE_ADDR_CONTROL, 32'h4045);
    go(16'hC045);
    wait_idle();
    peek(16'hF03E, 32'hFFFF);
    peek(16'hF004, 32'hBEEF);
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, DEE_ADDR_TBL_PTR, 32'hF020 + 32'(2 * i));
      bus(1'b1, DEE_ADDR_TBL_DATA, 32'hA500 + 32'(i));
    end
    bus(1'b1, DEE_ADDR_CONTROL, 32'h400A);
    go(16'hC00A);
    wait_idle();
    for (int i = 0; i < 16; i++) peek(16'hF020 + 16'(2 * i), 32'hA500 + 32'(i));
    bus(1'b1, DEE_ADDR_TBL_DATA, 32'h0);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, DEE_ADDR_CONTROL, 32'h4044);
      go(16'hC044);
      @(posedge pclk);
      {watchdog_timeout, master_clear_reset} <= 2'(k + 1);
      @(posedge pclk);
      {watchdog_timeout, master_clear_reset} <= 2'b00;
      @(negedge pclk);
      `CHK(nvm_busy, 1'b0)
      rd_chk(DEE_ADDR_CONTROL, 32'h2000);
      rd_chk(DEE_ADDR_ADDR_LOW, 32'hF03E);
    end
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(DEE_ADDR_CONTROL, 32'h0);
    close_out();
  end
endmodule : tb
